/* design/sram_port_pkg.sv */
// constants, state codes and pin widths for the synchronous burst sram port
// assumes: one 50 MHz system clock, x18 organisation (two 9-bit byte lanes)
package sram_port_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned ADDR_W  = 20;
  localparam int unsigned DEPTH   = 1 << ADDR_W;
  localparam int unsigned DQ_W    = 16;
  localparam int unsigned PAR_W   = 2;
  localparam int unsigned LANES   = 2;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned LANE_W  = BYTE_W + 1;
  localparam int unsigned LOW_W   = 2;
  localparam int unsigned HIGH_W  = ADDR_W - LOW_W;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [LANES-1:0] ALL_LANES   = 2'h3;
  localparam logic [LANES-1:0] NO_LANES    = 2'h0;
  localparam logic [LOW_W-1:0] STEP_ONE    = 2'h1;
  localparam logic             MODE_RST    = 1'h1;
  localparam logic             SLEEP_RST   = 1'h0;

  // ****************************************
  // access state, one-hot
  // ****************************************
  typedef enum logic [2:0] {
    ST_DESEL = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } access_e;

endpackage : sram_port_pkg

/* design/burst_addr_gen.sv */
// two-bit burst address counter, linear or interleaved order
// assumes: load and advance are never both high; same clock as the port
`timescale 1ns/100ps
module burst_addr_gen (
  // clock and reset
  input  wire logic                             clk_sys_i,
  input  wire logic                             sys_rst_i,
  // control
  input  wire logic                             load_i,
  input  wire logic [sram_port_pkg::LOW_W-1:0]  load_val_i,
  input  wire logic                             step_i,
  input  wire logic                             interleave_i,
  // low address bits of the current access
  output logic      [sram_port_pkg::LOW_W-1:0]  low_o
);

  typedef struct packed {
    logic [sram_port_pkg::LOW_W-1:0] base;
    logic [sram_port_pkg::LOW_W-1:0] step;
  } burst_s;

  burst_s cur_q;
  burst_s nxt_d;
  logic [sram_port_pkg::LOW_W-1:0] step_sel;

  // ****************************************
  // address for this edge
  // ****************************************
  assign step_sel = step_i ? cur_q.step + sram_port_pkg::STEP_ONE : cur_q.step;

  always_comb begin
    if (load_i) begin
      low_o = load_val_i;
    end else if (interleave_i) begin
      low_o = cur_q.base ^ step_sel;
    end else begin
      low_o = cur_q.base + step_sel;
    end
  end

  // ****************************************
  // counter state
  // ****************************************
  // step wraps after four, so a burst never leaves its aligned group
  always_comb begin
    nxt_d = cur_q;
    if (load_i) begin
      nxt_d.base = load_val_i;
      nxt_d.step = '0;
    end else if (step_i) begin
      nxt_d.step = step_sel;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

endmodule : burst_addr_gen

/* design/sram_array.sv */
// storage array with registered write data and registered read data
// assumes: one access per edge; write commits one edge after capture
`timescale 1ns/100ps
module sram_array (
  // clock and reset
  input  wire logic                                          clk_sys_i,
  input  wire logic                                          sys_rst_i,
  // access
  input  wire logic [sram_port_pkg::ADDR_W-1:0]              addr_i,
  input  wire logic [sram_port_pkg::LANES-1:0]               wr_lanes_i,
  input  wire logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] wr_data_i,
  // read data
  output logic      [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] rd_data_o
);

  typedef struct packed {
    logic [sram_port_pkg::ADDR_W-1:0]                      pend_addr;
    logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] pend_data;
    logic [sram_port_pkg::LANES-1:0]                       pend_lanes;
    logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] rdata;
  } array_s;

  array_s cur_q;
  array_s nxt_d;
  logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] mem [0:sram_port_pkg::DEPTH-1];

  // ****************************************
  // capture and read with bypass
  // ****************************************
  // the pending write is not yet in mem, so a read of its address takes it from the register
  always_comb begin
    nxt_d            = cur_q;
    nxt_d.pend_addr  = addr_i;
    nxt_d.pend_data  = wr_data_i;
    nxt_d.pend_lanes = wr_lanes_i;
    nxt_d.rdata      = mem[addr_i];
    for (int i = 0; i < sram_port_pkg::LANES; i++) begin
      if (cur_q.pend_lanes[i] && cur_q.pend_addr == addr_i) begin
        nxt_d.rdata[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
          cur_q.pend_data[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ****************************************
  // self-timed commit, contents survive reset
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < sram_port_pkg::LANES; i++) begin
      if (cur_q.pend_lanes[i]) begin
        mem[cur_q.pend_addr][i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] <=
          cur_q.pend_data[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
      end
    end
  end

  assign rd_data_o = cur_q.rdata;

endmodule : sram_array

/* design/sync_burst_sram_port.sv */
// synchronous flow-through burst sram host port, x18 organisation
// assumes: address and control pins are synchronous to clk_sys_i;
// sleep request may change at any time; burst order strap is held steady by the system
//
// What this block does
// RQ1 - every synchronous pin is sampled on the rising edge of the clock
// RQ2 - advance sampled low during a burst steps the burst counter
// RQ3 - primary select is active low and joins the other selects
// RQ4 - processor strobe is ignored while primary select is high
// RQ5 - high depth select is active high and joins the select decision
// RQ6 - low depth select is active low and joins the select decision
// RQ7 - output enable low drives data and parity, unless auto tri-state applies
// RQ8 - output enable high releases data and parity as inputs
// RQ9 - first clock of a read after deselect keeps data undriven
// RQ10 - processor strobe captures address and seeds counter with low two bits
// RQ11 - controller strobe captures address and seeds counter with low two bits
// RQ12 - both strobes together: only the processor strobe counts
// RQ13 - sleep request high idles the port and keeps stored data
// RQ14 - input data is captured into a write-data register at the edge
// RQ15 - read data is the location addressed at the preceding edge
// RQ16 - outputs stay off in writes, after deselect and while deselected
// RQ17 - parity lines act like data, written under their byte-lane select
// RQ18 - burst order strap low is linear, high or open is interleaved
// RQ19 - the system holds the burst order strap steady in operation
// RQ20 - low two address bits seed a two-bit counter, four beats at most
// RQ21 - all-bytes write low writes every lane regardless of lane selects
// RQ22 - byte write needs the qualifier low, then each lane select enables its byte
// RQ23 - linear steps modulo four; interleaved xors the seed with the step
// RQ24 - selected only with primary and low-depth low and high-depth high
`timescale 1ns/100ps
module sync_burst_sram_port (
  // clock and reset
  input  wire logic                                clk_sys_i,
  input  wire logic                                sys_rst_i,
  // address and select pins
  input  wire logic [sram_port_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic                                primary_select_n_i,
  input  wire logic                                depth_select_hi_i,
  input  wire logic                                depth_select_lo_n_i,
  // burst control pins
  input  wire logic                                cpu_addr_strobe_n_i,
  input  wire logic                                ctrl_addr_strobe_n_i,
  input  wire logic                                burst_advance_n_i,
  // write control pins
  input  wire logic                                all_bytes_write_n_i,
  input  wire logic                                byte_write_qualifier_n_i,
  input  wire logic [sram_port_pkg::LANES-1:0]     byte_lane_select_n_i,
  // asynchronous and static pins
  input  wire logic                                output_enable_n_i,
  input  wire logic                                sleep_request_i,
  input  wire logic                                burst_order_i,
  // data pins
  input  wire logic [sram_port_pkg::DQ_W-1:0]      dq_i,
  output logic      [sram_port_pkg::DQ_W-1:0]      dq_o,
  output logic                                     dq_oe_n_o,
  // parity pins
  input  wire logic [sram_port_pkg::PAR_W-1:0]     parity_lines_i,
  output logic      [sram_port_pkg::PAR_W-1:0]     parity_lines_o,
  output logic                                     parity_lines_oe_n_o,
  // status
  output logic                                     asleep_o
);

  typedef struct packed {
    sram_port_pkg::access_e           state;
    logic [sram_port_pkg::ADDR_W-1:0] used_addr;
    logic                             sleep_meta;
    logic                             sleep_q;
    logic                             mode_meta;
    logic                             mode_q;
  } port_s;

  port_s cur_q;
  port_s nxt_d;

  logic                                            asleep;
  logic                                            sel;
  logic                                            p_take;
  logic                                            c_take;
  logic                                            active;
  logic                                            load;
  logic                                            cont;
  logic                                            step_go;
  logic [sram_port_pkg::LANES-1:0]                 lanes_req;
  logic                                            wr_req;
  logic                                            wr_go;
  logic [sram_port_pkg::LANES-1:0]                 lanes_go;
  logic [sram_port_pkg::LOW_W-1:0]                 burst_low;
  logic [sram_port_pkg::ADDR_W-1:0]                access_addr;
  logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] wr_word;
  logic [sram_port_pkg::LANES*sram_port_pkg::LANE_W-1:0] rd_word;
  logic                                            drive;

  // ****************************************
  // access decode at the clock edge
  // ****************************************
  assign asleep = cur_q.sleep_q;                                                // RQ13
  assign sel    = ~primary_select_n_i & depth_select_hi_i & ~depth_select_lo_n_i; // RQ3 RQ5 RQ6 RQ24
  assign p_take = ~asleep & ~cpu_addr_strobe_n_i & ~primary_select_n_i;         // RQ4
  assign c_take = ~asleep & ~ctrl_addr_strobe_n_i & ~p_take;                    // RQ12
  assign active = cur_q.state != sram_port_pkg::ST_DESEL;
  assign load   = (p_take | c_take) & sel;                                      // RQ10 RQ11
  assign cont   = ~asleep & ~p_take & ~c_take & active;
  assign step_go = cont & ~burst_advance_n_i;                                   // RQ2

  // all-bytes write overrides the lane selects; otherwise the qualifier gates them
  always_comb begin
    if (!all_bytes_write_n_i) begin
      lanes_req = sram_port_pkg::ALL_LANES;                                     // RQ21
    end else if (!byte_write_qualifier_n_i) begin
      lanes_req = ~byte_lane_select_n_i;                                        // RQ22
    end else begin
      lanes_req = sram_port_pkg::NO_LANES;
    end
  end

  // a processor-strobe access always opens as a read; its write follows in a later cycle
  assign wr_req   = |lanes_req;
  assign wr_go    = ~p_take & (load | cont) & wr_req;
  assign lanes_go = wr_go ? lanes_req : sram_port_pkg::NO_LANES;

  // ****************************************
  // burst counter and address
  // ****************************************
  burst_addr_gen u_burst (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .load_i       (load),
    .load_val_i   (addr_i[sram_port_pkg::LOW_W-1:0]),                           // RQ20
    .step_i       (step_go),
    .interleave_i (cur_q.mode_q),                                               // RQ18 RQ23
    .low_o        (burst_low)
  );

  assign access_addr = {load ? addr_i[sram_port_pkg::ADDR_W-1:sram_port_pkg::LOW_W]
                             : cur_q.used_addr[sram_port_pkg::ADDR_W-1:sram_port_pkg::LOW_W],
                        burst_low};

  // ****************************************
  // storage, parity rides in bit 8 of each lane
  // ****************************************
  assign wr_word = {parity_lines_i[1], dq_i[15:8], parity_lines_i[0], dq_i[7:0]}; // RQ17

  sram_array u_array (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .addr_i     (access_addr),
    .wr_lanes_i (lanes_go),                                                     // RQ14
    .wr_data_i  (wr_word),
    .rd_data_o  (rd_word)                                                       // RQ15
  );

  // ****************************************
  // state update
  // ****************************************
  // the strap is only read after two flops; a moving strap is the system's fault
  always_comb begin
    nxt_d           = cur_q;
    nxt_d.sleep_meta = sleep_request_i;
    nxt_d.sleep_q    = cur_q.sleep_meta;
    nxt_d.mode_meta = burst_order_i;
    nxt_d.mode_q    = cur_q.mode_meta;                                          // RQ19
    nxt_d.used_addr = access_addr;                                              // RQ1
    case (1'b1)
      asleep: begin
        nxt_d.state = sram_port_pkg::ST_DESEL;                                  // RQ13
      end
      p_take, c_take: begin
        if (!sel) begin
          nxt_d.state = sram_port_pkg::ST_DESEL;
        end else if (wr_go) begin
          nxt_d.state = sram_port_pkg::ST_WRITE;
        end else begin
          nxt_d.state = sram_port_pkg::ST_READ;
        end
      end
      cont: begin
        nxt_d.state = wr_go ? sram_port_pkg::ST_WRITE : sram_port_pkg::ST_READ;
      end
      default: begin
        nxt_d.state = sram_port_pkg::ST_DESEL;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cur_q           <= '0;
      cur_q.state     <= sram_port_pkg::ST_DESEL;
      cur_q.sleep_meta <= sram_port_pkg::SLEEP_RST;
      cur_q.sleep_q    <= sram_port_pkg::SLEEP_RST;
      cur_q.mode_meta <= sram_port_pkg::MODE_RST;
      cur_q.mode_q    <= sram_port_pkg::MODE_RST;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // output enable acts without the clock: it only gates the pad, it holds no state.
  // a read out of deselect enters ST_READ only after its edge, so its first clock is undriven.
  assign drive = (cur_q.state == sram_port_pkg::ST_READ) & ~output_enable_n_i & ~asleep; // RQ7 RQ9 RQ16

  assign dq_oe_n_o           = ~drive;                                          // RQ8
  assign parity_lines_oe_n_o = ~drive;                                          // RQ17
  assign dq_o                = {rd_word[16:9], rd_word[7:0]};
  assign parity_lines_o      = {rd_word[17], rd_word[8]};
  assign asleep_o            = cur_q.sleep_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_oe_high_releases;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      output_enable_n_i |-> dq_oe_n_o && parity_lines_oe_n_o;
  endproperty
  a_oe_high_releases: assert property (p_oe_high_releases) else $error("pins driven with oe high"); // RQ8

  property p_read_drives;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (load && !wr_go && !output_enable_n_i) ##1 (!output_enable_n_i && !asleep) |-> !dq_oe_n_o;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("read not driven with oe low"); // RQ7

  property p_no_drive_off;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ((p_take || c_take) && !sel) || wr_go |=> dq_oe_n_o;
  endproperty
  a_no_drive_off: assert property (p_no_drive_off) else $error("driven while deselected or writing"); // RQ16

  property p_first_read_quiet;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !active && !load |=> dq_oe_n_o;
  endproperty
  a_first_read_quiet: assert property (p_first_read_quiet) else $error("driven in first read clock"); // RQ9

  property p_cpu_ignored;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !cpu_addr_strobe_n_i && primary_select_n_i && ctrl_addr_strobe_n_i && !asleep
      |=> (cur_q.state == sram_port_pkg::ST_DESEL) == !$past(active);
  endproperty
  a_cpu_ignored: assert property (p_cpu_ignored) else $error("strobe taken with select high"); // RQ4

  property p_cpu_wins;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !asleep && !cpu_addr_strobe_n_i && !ctrl_addr_strobe_n_i && sel && !all_bytes_write_n_i
      |=> cur_q.state == sram_port_pkg::ST_READ && cur_q.used_addr == $past(addr_i);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("controller strobe won over processor"); // RQ12

  property p_load_addr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      c_take && sel |=> cur_q.used_addr == $past(addr_i) && cur_q.state != sram_port_pkg::ST_DESEL;
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("address not loaded on strobe"); // RQ11

  property p_deselect;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (p_take || c_take) && (primary_select_n_i || !depth_select_hi_i || depth_select_lo_n_i)
      |=> cur_q.state == sram_port_pkg::ST_DESEL;
  endproperty
  a_deselect: assert property (p_deselect) else $error("selected with a select inactive"); // RQ24

  property p_linear_step;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      step_go && !cur_q.mode_q |=> cur_q.used_addr[1:0] == $past(cur_q.used_addr[1:0]) + 2'h1;
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear burst step wrong"); // RQ23

  property p_hold_no_adv;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      cont && burst_advance_n_i |=> cur_q.used_addr == $past(cur_q.used_addr);
  endproperty
  a_hold_no_adv: assert property (p_hold_no_adv) else $error("address moved without advance"); // RQ2

  property p_global_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      c_take && sel && !all_bytes_write_n_i |=> cur_q.state == sram_port_pkg::ST_WRITE;
  endproperty
  a_global_write: assert property (p_global_write) else $error("global write not taken"); // RQ21

  property p_no_qualifier;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      c_take && sel && all_bytes_write_n_i && byte_write_qualifier_n_i
      |=> cur_q.state == sram_port_pkg::ST_READ;
  endproperty
  a_no_qualifier: assert property (p_no_qualifier) else $error("byte write without qualifier"); // RQ22

  property p_sleep;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      sleep_request_i [*3] |=> cur_q.state == sram_port_pkg::ST_DESEL && dq_oe_n_o && asleep_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("port active during sleep"); // RQ13

  c_read_burst: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cur_q.state == sram_port_pkg::ST_READ [*4]);
  c_write_burst: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cur_q.state == sram_port_pkg::ST_WRITE [*2]);
  c_driven_read: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) !dq_oe_n_o);
  c_sleep: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) asleep_o);

endmodule : sync_burst_sram_port

/* bench/host_bus_model.sv */
// processor-side model that drives every synchronous pin of the port
// assumes: the bench merges write data with the port's drive onto one wire
`timescale 1ns/100ps
module host_bus_model (
  // clock
  input  wire logic                             clk_sys_i,
  // pins toward the port
  output logic      [sram_port_pkg::ADDR_W-1:0] addr_o,
  output logic      [2:0]                       sel_o,
  output logic      [4:0]                       ctl_n_o,
  output logic      [1:0]                       lanes_n_o,
  output logic      [17:0]                      wdata_o
);
  // ****************************************
  // one bus cycle per call
  // ****************************************
  initial begin
    addr_o = '0;
    sel_o = 3'h4;
    ctl_n_o = 5'h1F;
    lanes_n_o = 2'h3;
    wdata_o = 18'h00000;
  end

  // pins change just after an edge and hold until the next edge
  task automatic cyc(input logic [2:0] sel, input logic [4:0] ctl, input logic [1:0] ln,
                     input logic [19:0] a, input logic [17:0] d);
    sel_o = sel;
    ctl_n_o = ctl;
    lanes_n_o = ln;
    addr_o = a;
    // outside writes the old value is never left standing on the bus
    wdata_o = (ctl[1] & ctl[0]) ? ~wdata_o : d;
    @(posedge clk_sys_i);
    #1;
  endtask : cyc
endmodule : host_bus_model

/* bench/tb.sv */
// self-checking bench for the burst sram port
// assumes: host model drives the bus, bench drives the asynchronous pins
`timescale 1ns/100ps
module tb;
  // ****************************************
  // bench
  // ****************************************
  localparam logic [19:0] BASE = 20'h00A40;
  localparam logic [2:0]  SEL = 3'h2;
  localparam logic [4:0]  IDLE = 5'h1F, CPU = 5'h0F, CTRL = 5'h17, STEP = 5'h1B;
  localparam logic [4:0]  ALL_WR = 5'h15, LANE_WR = 5'h16, BOTH_WR = 5'h05;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        oe_n = 1'b0;
  logic        sleep = 1'b0;
  logic        order = 1'b1;
  logic [19:0] addr;
  logic [2:0]  sel;
  logic [4:0]  ctl;
  logic [1:0]  ln, rd_par;
  logic [17:0] hd, rd, oes;
  logic [15:0] rd_dq;
  logic        dq_oe_n, par_oe_n, asleep;
  logic [17:0] mem [4];
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;

  assign rd = {rd_par, rd_dq};
  assign oes = {16'h0000, dq_oe_n, par_oe_n};
  always #10 clk_sys_i = ~clk_sys_i;

  host_bus_model i_host (.clk_sys_i(clk_sys_i), .addr_o(addr), .sel_o(sel), .ctl_n_o(ctl),
                         .lanes_n_o(ln), .wdata_o(hd));

  sync_burst_sram_port i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .primary_select_n_i(sel[2]), .depth_select_hi_i(sel[1]), .depth_select_lo_n_i(sel[0]),
    .cpu_addr_strobe_n_i(ctl[4]), .ctrl_addr_strobe_n_i(ctl[3]), .burst_advance_n_i(ctl[2]),
    .all_bytes_write_n_i(ctl[1]), .byte_write_qualifier_n_i(ctl[0]), .byte_lane_select_n_i(ln),
    .output_enable_n_i(oe_n), .sleep_request_i(sleep), .burst_order_i(order),
    .dq_i(dq_oe_n ? hd[15:0] : rd_dq), .dq_o(rd_dq), .dq_oe_n_o(dq_oe_n),
    .parity_lines_i(par_oe_n ? hd[17:16] : rd_par), .parity_lines_o(rd_par),
    .parity_lines_oe_n_o(par_oe_n), .asleep_o(asleep));

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_write_read();
    for (int i = 0; i < 4; i++) begin
      mem[i] = 18'h2C3A5 ^ (18'h15555 >> i);
      i_host.cyc(SEL, ALL_WR, 2'h3, BASE + 20'(i), mem[i]);
      chk(oes, 18'h00003);
    end
    i_host.cyc(SEL, CPU, 2'h3, BASE + 20'h3, 18'h00000);
    chk(rd, mem[3]);
    chk(oes, 18'h00000);
  endtask : t_write_read

  task automatic t_burst(input logic m);
    i_host.cyc(3'h4, CTRL, 2'h3, BASE, 18'h00000);
    order = m;
    repeat (3) i_host.cyc(3'h4, IDLE, 2'h3, BASE, 18'h00000);
    i_host.cyc(SEL, CPU, 2'h3, BASE + 20'h1, 18'h00000);
    chk(rd, mem[1]);
    for (int s = 1; s < 4; s++) begin
      i_host.cyc(SEL, STEP, 2'h3, BASE, 18'h00000);
      chk(rd, mem[m ? (1 ^ s) : ((1 + s) % 4)]);
    end
  endtask : t_burst

  task automatic t_bytes();
    // the burst read still drives the bus, so output enable turns it round for the write
    oe_n = 1'b1;
    i_host.cyc(SEL, LANE_WR, 2'h2, BASE, 18'h3FFFF);
    oe_n = 1'b0;
    mem[0] = (mem[0] & 18'h2FF00) | 18'h100FF;
    i_host.cyc(SEL, CTRL, 2'h0, BASE + 20'h1, 18'h00000);
    chk(rd, mem[1]);
    i_host.cyc(SEL, CTRL, 2'h3, BASE + 20'h1, 18'h00000);
    chk(rd, mem[1]);
    i_host.cyc(SEL, CTRL, 2'h3, BASE, 18'h00000);
    chk(rd, mem[0]);
  endtask : t_bytes

  task automatic t_select();
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    for (int k = 0; k < 3; k++) begin
      i_host.cyc(SEL, CTRL, 2'h3, BASE + 20'h2, 18'h00000);
      chk(oes, 18'h00000);
      i_host.cyc(bad[k], CTRL, 2'h3, BASE, 18'h00000);
      chk(oes, 18'h00003);
    end
    i_host.cyc(SEL, CTRL, 2'h3, BASE + 20'h2, 18'h00000);
    i_host.cyc(3'h6, CPU, 2'h3, BASE + 20'h3, 18'h00000);
    chk(rd, mem[2]);
    chk(oes, 18'h00000);
    i_host.cyc(SEL, BOTH_WR, 2'h3, BASE + 20'h3, 18'h00000);
    chk(rd, mem[3]);
    chk(oes, 18'h00000);
    i_host.cyc(SEL, CTRL, 2'h3, BASE + 20'h3, 18'h00000);
    chk(rd, mem[3]);
    oe_n = 1'b1;
    #1;
    chk(oes, 18'h00003);
    oe_n = 1'b0;
    #1;
    chk(oes, 18'h00000);
  endtask : t_select

  task automatic t_sleep();
    sleep = 1'b1;
    repeat (4) i_host.cyc(SEL, IDLE, 2'h3, BASE, 18'h00000);
    chk({17'h00000, asleep}, 18'h00001);
    chk(oes, 18'h00003);
    i_host.cyc(SEL, ALL_WR, 2'h3, BASE, 18'h00000);
    sleep = 1'b0;
    repeat (4) i_host.cyc(SEL, IDLE, 2'h3, BASE, 18'h00000);
    chk({17'h00000, asleep}, 18'h00000);
    i_host.cyc(SEL, CPU, 2'h3, BASE, 18'h00000);
    chk(rd, mem[0]);
  endtask : t_sleep

  // ****************************************
  // run and watchdog
  // ****************************************
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    chk(oes, 18'h00003);
    t_write_read();
    t_burst(1'b0);
    t_burst(1'b1);
    t_bytes();
    t_select();
    t_sleep();
    test_done();
  end
endmodule : tb
